// ---- src/xie_pkg.sv ----
// Purpose: Shared constants and types for the exclusive-OR execute unit.
// Assumes: 24-bit instruction words, 16-bit data, AHB-Lite register access.
// Notes: Register offsets are byte addresses on a 32-bit bus.
package xie_pkg;
  // ==========================================================================
  // Opcodes and field values
  // ==========================================================================
  localparam logic [7:0] OPC_MEM = 8'hB6;
  localparam logic [7:0] OPC_WLIT = 8'hB2;
  localparam logic [4:0] OPC_REG5 = 5'h0D;
  localparam logic [1:0] LIT_TAG = 2'h3;
  localparam logic [3:0] ACCUM_IDX = 4'h0;
  localparam logic [12:0] MEM_LOC_MAX = 13'h1FFF;
  // ==========================================================================
  // Addressing modes
  // ==========================================================================
  localparam logic [2:0] AM_DIR = 3'h0;
  localparam logic [2:0] AM_IND = 3'h1;
  localparam logic [2:0] AM_POSTDEC = 3'h2;
  localparam logic [2:0] AM_POSTINC = 3'h3;
  localparam logic [2:0] AM_PREDEC = 3'h4;
  localparam logic [2:0] AM_PREINC = 3'h5;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  // ==========================================================================
  // Status word and register map
  // ==========================================================================
  localparam int N_BIT = 3;
  localparam int Z_BIT = 1;
  localparam logic [7:0] REG_DEFAULT_ACCUM_REG_BASE = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h40;
  localparam logic [7:0] REG_CTRL = 8'h44;
  localparam logic [7:0] REG_INFO = 8'h48;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int INFO_BUSY_BIT = 0;
  localparam int INFO_ILLEGAL_BIT = 1;
  localparam logic CTRL_ENABLE_RST = 1'b1;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] DEFAULT_ACCUM_REG_RST = 16'h0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic {ST_IDLE, ST_READ} xie_state_t;
endpackage : xie_pkg

// ---- src/xie_operand_addr.sv ----
// Purpose: Effective address and pointer update for one operand.
// Assumes: Modes 0 to 5; other codes mean no memory access.
// Notes: Purely combinational.
`timescale 1ns/10ps
module xie_operand_addr
  import xie_pkg::*;
(
  input wire logic [2:0] i_mode,      // Addressing mode field
  input wire logic [15:0] i_ptr,      // Register value used as pointer
  input wire logic i_byte,            // Byte operation
  output logic [15:0] o_ea,           // Effective byte address
  output logic [15:0] o_new_ptr,      // Pointer after update
  output logic o_is_mem,              // Operand lives in data memory
  output logic o_ptr_upd              // Pointer is written back
);
  logic [15:0] step;

  always_comb begin
    step = i_byte ? STEP_BYTE : STEP_WORD;
    o_ea = i_ptr;
    o_new_ptr = i_ptr;
    o_is_mem = 1'b1;
    o_ptr_upd = 1'b0;
    case (i_mode)
      AM_DIR: begin
        o_is_mem = 1'b0;
      end
      AM_IND: begin
        o_is_mem = 1'b1;
      end
      AM_POSTDEC: begin
        o_new_ptr = i_ptr - step;
        o_ptr_upd = 1'b1;
      end
      AM_POSTINC: begin
        o_new_ptr = i_ptr + step;
        o_ptr_upd = 1'b1;
      end
      AM_PREDEC: begin
        o_ea = i_ptr - step;
        o_new_ptr = i_ptr - step;
        o_ptr_upd = 1'b1;
      end
      AM_PREINC: begin
        o_ea = i_ptr + step;
        o_new_ptr = i_ptr + step;
        o_ptr_upd = 1'b1;
      end
      default: begin
        o_is_mem = 1'b0;
      end
    endcase
  end
endmodule : xie_operand_addr

// ---- src/xie_core.sv ----
// Purpose: Decode and execute the four exclusive-OR instruction forms.
// Assumes: Data memory answers reads with i_dm_rvalid; writes take one pulse.
// Notes: Working registers and status word are also reachable over AHB-Lite.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - Memory form XORs working register zero with data location 0 to 8191.
// - Memory form result goes to working register zero or back to memory.
// - Memory form found by upper opcode byte; low thirteen bits give location.
// - The implicit accumulator of the memory form is working register zero.
// - Size bit zero means word, one means byte, in every form.
// - Only negative and zero flags change, taken at the operand size.
// - Each form executes in one cycle; memory reads may add wait cycles.
// - Wide literal XORs a register directly and writes back to it.
// - Wide literal form carries size bit, ten literal bits, register nibble.
// - Short literal XORs base register with 0 to 31 into any destination.
// - Short literal fields: base, size, destination mode, register, literal.
// - Register form XORs base with source; source and destination may be indirect.
// - Register form takes source mode and register from the lowest seven bits.
// - Destination may be direct or indirect with post or pre pointer update.
module xie_core
  import xie_pkg::*;
(
  input wire logic i_sys_clk,          // System clock, 40 MHz
  input wire logic i_rst,              // Asynchronous reset, active high
  input wire logic i_hsel,             // AHB slave select
  input wire logic [31:0] i_haddr,     // AHB address
  input wire logic [1:0] i_htrans,     // AHB transfer type
  input wire logic i_hwrite,           // AHB write
  input wire logic [2:0] i_hsize,      // AHB size, word only
  input wire logic [31:0] i_hwdata,    // AHB write data
  input wire logic i_hready,           // AHB bus ready
  output logic [31:0] o_hrdata,        // AHB read data
  output logic o_hreadyout,            // AHB slave ready
  output logic o_hresp,                // AHB response, always OKAY
  input wire logic i_insn_valid,       // Instruction word offered
  input wire logic [23:0] i_insn,      // Instruction word
  output logic o_insn_ready,           // Instruction taken this edge
  output logic o_retire,               // Pulse: instruction finished
  output logic o_dm_re,                // Pulse: data memory read
  output logic [15:0] o_dm_raddr,      // Read byte address
  input wire logic i_dm_rvalid,        // Read data valid
  input wire logic [15:0] i_dm_rdata,  // Read data, aligned word
  output logic o_dm_we,                // Pulse: data memory write
  output logic [15:0] o_dm_waddr,      // Write byte address
  output logic [15:0] o_dm_wdata,      // Write data
  output logic [1:0] o_dm_be           // Write byte enables
);
  typedef struct packed {
    logic [15:0][15:0] default_accum_reg;
    logic [15:0] status_word;
    logic enable;
    logic illegal;
    logic [15:0] retired;
    xie_state_t fsm;
    logic [23:0] insn;
    logic [15:0] src_ea;
    logic dm_re;
    logic [15:0] dm_raddr;
    logic dm_we;
    logic [15:0] dm_waddr;
    logic [15:0] dm_wdata;
    logic [1:0] dm_be;
    logic retire;
    logic ahb_sel;
    logic ahb_write;
    logic [7:0] ahb_addr;
    logic [31:0] hrdata;
  } xie_regs_t;

  xie_regs_t r;
  xie_regs_t next_r;

  // ==========================================================================
  // Decode
  // ==========================================================================
  logic [23:0] cur;
  logic is_mem_form;
  logic is_wlit;
  logic is_reg5;
  logic is_slit;
  logic is_rreg;
  logic byte_op;
  logic [3:0] base_idx;
  logic [3:0] dst_idx;
  logic [3:0] src_idx;
  logic [2:0] dmode;
  logic [2:0] smode;
  logic [12:0] mem_loc;
  logic illegal_op;
  logic needs_read;
  logic [15:0] s_ea;
  logic [15:0] s_new;
  logic s_mem;
  logic s_upd;
  logic [15:0] d_ea;
  logic [15:0] d_new;
  logic d_mem;
  logic d_upd;

  always_comb begin
    cur = (r.fsm == ST_IDLE) ? i_insn : r.insn;
    is_mem_form = (cur[23:16] == OPC_MEM) && !cur[15];
    is_wlit = (cur[23:16] == OPC_WLIT) && cur[15];
    is_reg5 = (cur[23:19] == OPC_REG5);
    is_slit = is_reg5 && (cur[6:5] == LIT_TAG);
    is_rreg = is_reg5 && !is_slit;
    byte_op = cur[14];
    base_idx = cur[18:15];
    dmode = cur[13:11];
    dst_idx = cur[10:7];
    smode = cur[6:4];
    src_idx = cur[3:0];
    mem_loc = cur[12:0];
    illegal_op = !(is_mem_form || is_wlit || is_reg5) || (is_reg5 && dmode > AM_PREINC);
    needs_read = is_mem_form || (is_rreg && s_mem);
  end

  xie_operand_addr u_src_addr (
    .i_mode(smode),
    .i_ptr(r.default_accum_reg[src_idx]),
    .i_byte(byte_op),
    .o_ea(s_ea),
    .o_new_ptr(s_new),
    .o_is_mem(s_mem),
    .o_ptr_upd(s_upd)
  );

  xie_operand_addr u_dst_addr (
    .i_mode(dmode),
    .i_ptr(r.default_accum_reg[dst_idx]),
    .i_byte(byte_op),
    .o_ea(d_ea),
    .o_new_ptr(d_new),
    .o_is_mem(d_mem),
    .o_ptr_upd(d_upd)
  );

  // ==========================================================================
  // Operands and result
  // ==========================================================================
  logic [15:0] mem_val;
  logic [15:0] opnd_a;
  logic [15:0] opnd_b;
  logic [15:0] result;
  logic flag_n;
  logic flag_z;
  logic accept;
  logic execute;
  logic ahb_addr_phase;
  logic ahb_mapped_default_accum_reg;

  always_comb begin
    mem_val = r.src_ea[0] ? {8'h00, i_dm_rdata[15:8]} : {8'h00, i_dm_rdata[7:0]};
    if (!byte_op) begin
      mem_val = i_dm_rdata;
    end
    opnd_a = r.default_accum_reg[base_idx];
    opnd_b = r.default_accum_reg[src_idx];
    if (is_mem_form) begin
      opnd_a = r.default_accum_reg[ACCUM_IDX];
      opnd_b = mem_val;
    end else if (is_wlit) begin
      opnd_a = r.default_accum_reg[cur[3:0]];
      opnd_b = {6'h00, cur[13:4]};
    end else if (is_slit) begin
      opnd_b = {11'h000, cur[4:0]};
    end else if (s_mem) begin
      opnd_b = mem_val;
    end
    result = opnd_a ^ opnd_b;
    flag_n = byte_op ? result[7] : result[15];
    flag_z = byte_op ? (result[7:0] == 8'h00) : (result == 16'h0000);
    accept = (r.fsm == ST_IDLE) && r.enable && i_insn_valid;
    execute = (accept && (illegal_op || !needs_read)) || ((r.fsm == ST_READ) && i_dm_rvalid);
    ahb_addr_phase = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ || i_htrans == 2'h3);
    ahb_mapped_default_accum_reg = (r.ahb_addr[7:6] == REG_DEFAULT_ACCUM_REG_BASE[7:6]);
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_r = r;
    next_r.dm_re = 1'b0;
    next_r.dm_we = 1'b0;
    next_r.retire = 1'b0;

    // Bus writes land first so that a retiring instruction wins a collision.
    if (r.ahb_sel && r.ahb_write) begin
      if (ahb_mapped_default_accum_reg) begin
        next_r.default_accum_reg[r.ahb_addr[5:2]] = i_hwdata[15:0];
      end else if (r.ahb_addr == REG_STATUS) begin
        next_r.status_word = i_hwdata[15:0];
      end else if (r.ahb_addr == REG_CTRL) begin
        next_r.enable = i_hwdata[CTRL_ENABLE_BIT];
      end else if (r.ahb_addr == REG_INFO) begin
        if (i_hwdata[INFO_ILLEGAL_BIT]) begin
          next_r.illegal = 1'b0;
        end
      end
    end

    if (accept && needs_read && !illegal_op) begin
      next_r.insn = i_insn;
      next_r.fsm = ST_READ;
      next_r.dm_re = 1'b1;
      next_r.src_ea = is_mem_form ? {3'h0, mem_loc} : s_ea;
      next_r.dm_raddr = is_mem_form ? {3'h0, mem_loc} : s_ea;
    end

    if (execute) begin
      next_r.fsm = ST_IDLE;
      next_r.retire = 1'b1;
      next_r.retired = r.retired + 16'h0001;
      if (illegal_op) begin
        next_r.illegal = 1'b1;
      end else begin
        next_r.status_word[N_BIT] = flag_n;
        next_r.status_word[Z_BIT] = flag_z;
        if (is_rreg && s_upd) begin
          next_r.default_accum_reg[src_idx] = s_new;
        end
        if (is_reg5 && d_upd) begin
          next_r.default_accum_reg[dst_idx] = d_new;
        end
        if ((is_mem_form && cur[13]) || (is_reg5 && d_mem)) begin
          next_r.dm_we = 1'b1;
          next_r.dm_waddr = is_mem_form ? {3'h0, mem_loc} : d_ea;
          if (byte_op) begin
            next_r.dm_wdata = {result[7:0], result[7:0]};
            next_r.dm_be = next_r.dm_waddr[0] ? 2'h2 : 2'h1;
          end else begin
            next_r.dm_wdata = result;
            next_r.dm_be = 2'h3;
          end
        end else begin
          if (is_mem_form) begin
            next_r.default_accum_reg[ACCUM_IDX] = byte_op ? {r.default_accum_reg[ACCUM_IDX][15:8], result[7:0]} : result;
          end else if (is_wlit) begin
            next_r.default_accum_reg[cur[3:0]] = byte_op ? {r.default_accum_reg[cur[3:0]][15:8], result[7:0]} : result;
          end else begin
            next_r.default_accum_reg[dst_idx] = byte_op ? {r.default_accum_reg[dst_idx][15:8], result[7:0]} : result;
          end
        end
      end
    end

    // Bus address phase; read data reflects every update of this cycle.
    next_r.ahb_sel = ahb_addr_phase;
    next_r.ahb_write = i_hwrite;
    next_r.ahb_addr = (i_haddr[31:8] == 24'h000000) ? i_haddr[7:0] : 8'hFF;
    if (ahb_addr_phase && !i_hwrite) begin
      next_r.hrdata = 32'h00000000;
      if (i_haddr[31:6] == 26'h0000000) begin
        next_r.hrdata = {16'h0000, next_r.default_accum_reg[i_haddr[5:2]]};
      end else if (i_haddr == {24'h000000, REG_STATUS}) begin
        next_r.hrdata = {16'h0000, next_r.status_word};
      end else if (i_haddr == {24'h000000, REG_CTRL}) begin
        next_r.hrdata = {31'h00000000, next_r.enable};
      end else if (i_haddr == {24'h000000, REG_INFO}) begin
        next_r.hrdata = {next_r.retired, 14'h0000, next_r.illegal, next_r.fsm == ST_READ};
      end
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
      r.enable <= CTRL_ENABLE_RST;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_hrdata = r.hrdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_insn_ready = (r.fsm == ST_IDLE) && r.enable;
  assign o_retire = r.retire;
  assign o_dm_re = r.dm_re;
  assign o_dm_raddr = r.dm_raddr;
  assign o_dm_we = r.dm_we;
  assign o_dm_waddr = r.dm_waddr;
  assign o_dm_wdata = r.dm_wdata;
  assign o_dm_be = r.dm_be;
endmodule : xie_core

// ---- sim/xie_core_asserts.sv ----
// Purpose: Port timing checks for the exclusive-OR execute unit.
// Assumes: One clock; i_rst clears all state except enable, which resets to one.
// Notes: Attached to the core by the bind below.
`timescale 1ns/10ps
module xie_core_asserts
  import xie_pkg::*;
(
  input wire logic i_sys_clk,          // Clock
  input wire logic i_rst,              // Reset
  input wire logic i_insn_valid,       // Offer
  input wire logic [23:0] i_insn,      // Word
  input wire logic o_insn_ready,       // Take
  input wire logic o_retire,           // Done
  input wire logic o_dm_re,            // Read
  input wire logic [15:0] o_dm_raddr,  // Read address
  input wire logic i_dm_rvalid,        // Read valid
  input wire logic o_dm_we,            // Write
  input wire logic [15:0] o_dm_waddr,  // Write address
  input wire logic [15:0] o_dm_wdata,  // Write data
  input wire logic [1:0] o_dm_be       // Lanes
);
  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  logic take;
  assign take = i_insn_valid && o_insn_ready;
  a_mem_read: assert property (take && i_insn[23:16] == OPC_MEM && !i_insn[15] |=>
    o_dm_re && o_dm_raddr == {3'h0, $past(i_insn[12:0])}) else $error("memory form read wrong");
  a_wait_hold: assert property (o_dm_re |-> !o_insn_ready && !o_retire)
    else $error("work taken while reading");
  a_read_done: assert property (i_dm_rvalid && !o_insn_ready |=> o_retire)
    else $error("no retire after read");
  a_lit_once: assert property (take && i_insn[23:16] == OPC_WLIT && i_insn[15] |=>
    o_retire && !o_dm_re && !o_dm_we) else $error("wide literal not single cycle");
  a_reg_direct: assert property (take && i_insn[23:19] == OPC_REG5 && i_insn[13:11] == AM_DIR
    && (i_insn[6:5] == LIT_TAG || i_insn[6:4] == AM_DIR) |=> o_retire && !o_dm_we && !o_dm_re)
    else $error("direct form touched memory");
  a_lit_store: assert property (take && i_insn[23:19] == OPC_REG5 && i_insn[6:5] == LIT_TAG
    && i_insn[13:11] inside {[3'h1:3'h5]} |=> o_dm_we && o_retire) else $error("literal store missing");
  a_byte_lane: assert property (o_dm_we && o_dm_be != 2'h3 |->
    o_dm_be == {o_dm_waddr[0], !o_dm_waddr[0]} && o_dm_wdata[15:8] == o_dm_wdata[7:0])
    else $error("byte write lane wrong");
  a_write_done: assert property (o_dm_we |-> o_retire)
    else $error("write without retire");
endmodule : xie_core_asserts

bind xie_core xie_core_asserts u_xie_asserts (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_insn_valid(i_insn_valid), .i_insn(i_insn), .o_insn_ready(o_insn_ready), .o_retire(o_retire),
  .o_dm_re(o_dm_re), .o_dm_raddr(o_dm_raddr), .i_dm_rvalid(i_dm_rvalid), .o_dm_we(o_dm_we),
  .o_dm_waddr(o_dm_waddr), .o_dm_wdata(o_dm_wdata), .o_dm_be(o_dm_be));

// ---- sim/xie_dmem_model.sv ----
// Purpose: Data memory behind the exclusive-OR execute unit.
// Assumes: Word array with byte lanes; read wait set by i_lat, at least 1.
// Notes: Read data scrambles every cycle outside its valid pulse.
`timescale 1ns/10ps
module xie_dmem_model (
  input wire logic i_clk,          // Clock
  input wire logic i_re,           // Read pulse
  input wire logic [15:0] i_raddr, // Read address
  input wire logic [3:0] i_lat,    // Read wait
  input wire logic i_we,           // Write pulse
  input wire logic [15:0] i_waddr, // Write address
  input wire logic [15:0] i_wdata, // Write data
  input wire logic [1:0] i_be,     // Lanes
  output logic o_rvalid,           // Data valid
  output logic [15:0] o_rdata      // Data
);
  logic [15:0] mem [0:32767];
  logic [14:0] ra;
  int cnt = 0;
  initial o_rvalid = 1'b0;
  initial o_rdata = 16'h0000;
  // Writes land at once, so a read issued alongside sees the new data.
  always @(posedge i_clk) begin
    if (i_we && i_be[0]) mem[i_waddr[15:1]][7:0] <= i_wdata[7:0];
    if (i_we && i_be[1]) mem[i_waddr[15:1]][15:8] <= i_wdata[15:8];
    o_rvalid <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_re) begin
      ra <= i_raddr[15:1];
      cnt <= i_lat;
    end else if (cnt == 1) begin
      o_rvalid <= 1'b1;
      o_rdata <= mem[ra];
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : xie_dmem_model

// ---- sim/xie_core_tb.sv ----
// Purpose: Self-checking bench for the exclusive-OR execute unit.
// Assumes: Zero-wait bus slave; data memory model with settable wait.
// Notes: Expected values come from operands chosen here.
`timescale 1ns/10ps
module xie_core_tb
  import xie_pkg::*;
;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, valid = 1'b0, rd_ph = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, be;
  logic [23:0] insn = 24'h0;
  logic [3:0] lat = 4'h1;
  logic hready, hresp, ready, retire, re, rvalid, we;
  logic [15:0] raddr, rdata, waddr, wdata, st;
  int fails = 0, check_count = 0;
  logic [31:0] rq[$];
  logic [47:0] wq[$];
  always #12.5 clk = ~clk;
  xie_core DUT (.i_sys_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_insn_valid(valid), .i_insn(insn), .o_insn_ready(ready),
    .o_retire(retire), .o_dm_re(re), .o_dm_raddr(raddr), .i_dm_rvalid(rvalid), .i_dm_rdata(rdata),
    .o_dm_we(we), .o_dm_waddr(waddr), .o_dm_wdata(wdata), .o_dm_be(be));
  xie_dmem_model dm (.i_clk(clk), .i_re(re), .i_raddr(raddr), .i_lat(lat), .i_we(we), .i_waddr(waddr),
    .i_wdata(wdata), .i_be(be), .o_rvalid(rvalid), .o_rdata(rdata));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask : ahb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask : rd
  task automatic rw(input logic [3:0] n, input logic [15:0] e);
    rd({2'h0, n, 2'h0}, {16'h0, e});
  endtask : rw
  task automatic setw(input logic [3:0] n, input logic [15:0] v);
    ahb(1'b1, {2'h0, n, 2'h0}, {16'h0, v});
  endtask : setw
  task automatic new_st();
    st = 16'($urandom);
    ahb(1'b1, REG_STATUS, {16'h0, st});
  endtask : new_st
  task automatic done_st(input logic b, input logic [15:0] r);
    rd(REG_STATUS, {16'h0, st[15:4], b ? r[7] : r[15], st[2], b ? r[7:0] == 8'h0 : r == 16'h0, st[0]});
  endtask : done_st
  task automatic note_wr(input logic b, input logic [15:0] a, input logic [15:0] r);
    wq.push_back(b ? {a, r[7:0], r[7:0], 14'h0, a[0], !a[0]} : {a, r, 16'h0003});
  endtask : note_wr
  task automatic exec(input logic [23:0] w);
    valid <= 1'b1;
    insn <= w;
    do @(posedge clk); while (ready !== 1'b1);
    valid <= 1'b0;
    do @(posedge clk); while (retire !== 1'b1);
  endtask : exec
  function automatic logic [15:0] keep(input logic b, input logic [15:0] d, input logic [15:0] x);
    return b ? {d[15:8], x[7:0]} : x;
  endfunction : keep
  // Read data is taken at the edge ending the data phase; writes as they pulse.
  always @(posedge clk) begin
    if (rd_ph) chk({hresp, hrdata}, rq.size() ? {1'b0, rq.pop_front()} : 33'hX);
    rd_ph <= hsel && htrans[1] && !hwrite && hready;
    if (we) chk({waddr, wdata, 14'h0, be}, wq.size() ? wq.pop_front() : 48'hX);
  end
  initial begin
    #100us;
    fails++;
    wrap_up();
  end
  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    logic b;
    logic [3:0] n;
    logic [9:0] k;
    logic [2:0] m;
    logic [15:0] v, s, p, q, r, sz, ea;
    void'($urandom(32'h05CF));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(REG_STATUS, {16'h0, STATUS_RST});
    ahb(1'b1, 8'h80, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0);
    $display("reset and map done");
    for (int i = 0; i < 16; i++) begin
      b = i[0];
      n = 4'($urandom);
      v = 16'($urandom);
      k = b ? 10'($urandom_range(255)) : 10'($urandom_range(1023));
      if (i < 2) k = b ? 10'h0FF : 10'h3FF;
      if (i == 2) v = {6'h0, k};
      setw(n, v);
      new_st();
      exec({OPC_WLIT, 1'b1, b, k, n});
      r = v ^ {6'h0, k};
      rw(n, keep(b, v, r));
      done_st(b, r);
    end
    $display("wide literal done");
    for (int i = 0; i < 8; i++) begin
      b = i[0];
      v = 16'($urandom);
      s = i == 2 ? v : 16'($urandom);
      p = 16'($urandom);
      setw(4'h1, v);
      setw(4'h5, s);
      setw(4'h9, p);
      new_st();
      exec({OPC_REG5, 4'h1, b, AM_DIR, 4'h9, AM_DIR, 4'h5});
      r = v ^ s;
      rw(4'h9, keep(b, p, r));
      done_st(b, r);
    end
    $display("register direct done");
    for (int i = 2; i < 12; i++) begin
      m = 3'(i / 2);
      b = i[0];
      v = 16'($urandom);
      k = 10'($urandom_range(31));
      p = 16'($urandom) & (b ? 16'hFFFF : 16'hFFFE);
      sz = b ? STEP_BYTE : STEP_WORD;
      ea = m > AM_POSTINC ? (m == AM_PREDEC ? p - sz : p + sz) : p;
      q = m == AM_IND ? p : (m == AM_POSTDEC || m == AM_PREDEC ? p - sz : p + sz);
      r = v ^ {11'h0, k[4:0]};
      setw(4'h2, v);
      setw(4'h8, p);
      new_st();
      note_wr(b, ea, r);
      exec({OPC_REG5, 4'h2, b, m, 4'h8, LIT_TAG, k[4:0]});
      rw(4'h8, q);
      done_st(b, r);
    end
    $display("short literal modes done");
    for (int i = 0; i < 4; i++) begin
      b = i[0];
      lat <= 4'(1 + 4 * i);
      v = 16'($urandom);
      s = 16'($urandom);
      p = 16'($urandom) & (b ? 16'hFFFF : 16'hFFFE);
      q = p ^ 16'h0100;
      sz = b ? STEP_BYTE : STEP_WORD;
      dm.mem[p[15:1]] = s;
      r = v ^ (b ? {8'h0, p[0] ? s[15:8] : s[7:0]} : s);
      setw(4'h1, v);
      setw(4'h5, p);
      setw(4'h9, q);
      new_st();
      note_wr(b, q, r);
      exec({OPC_REG5, 4'h1, b, AM_POSTINC, 4'h9, AM_POSTINC, 4'h5});
      rw(4'h5, p + sz);
      rw(4'h9, q + sz);
      done_st(b, r);
    end
    $display("indirect source done");
    for (int i = 0; i < 4; i++) begin
      b = i[0];
      lat <= 4'(i + 1);
      v = 16'($urandom);
      s = 16'($urandom);
      p = {3'h0, 13'($urandom)} & (b ? 16'hFFFF : 16'hFFFE);
      if (i == 3) p = {3'h0, MEM_LOC_MAX};
      dm.mem[p[15:1]] = s;
      r = v ^ (b ? {8'h0, p[0] ? s[15:8] : s[7:0]} : s);
      setw(ACCUM_IDX, v);
      new_st();
      if (i[1]) note_wr(b, p, r);
      exec({OPC_MEM, 1'b0, b, i[1], p[12:0]});
      rw(ACCUM_IDX, i[1] ? v : keep(b, v, r));
      done_st(b, r);
    end
    $display("memory form done");
    new_st();
    exec(24'hFF0000);
    rd(REG_INFO, {16'h002B, 14'h0, 2'h2});
    rd(REG_STATUS, {16'h0, st});
    ahb(1'b1, REG_INFO, 32'h2);
    ahb(1'b1, REG_CTRL, 32'h0);
    rd(REG_INFO, {16'h002B, 16'h0});
    valid <= 1'b1;
    insn <= {OPC_WLIT, 1'b1, 1'b0, 10'h3FF, 4'h3};
    repeat (3) @(posedge clk);
    chk(48'(ready), 48'h0);
    valid <= 1'b0;
    ahb(1'b1, REG_CTRL, 32'h1);
    rd(REG_INFO, {16'h002B, 16'h0});
    $display("illegal and disable done");
    repeat (4) @(posedge clk);
    chk(48'(wq.size() + rq.size()), 48'h0);
    wrap_up();
  end
endmodule : xie_core_tb
